// *** cpu_model.sv ***
// CPU-side partner: acknowledges requests and keeps the condition-code masks.
`timescale 1ns/1ps
module cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       set_i_i,
  input  wire logic       set_um_i,
  input  wire logic       ld_i,
  input  wire logic       ld_mask_i,
  input  wire logic       ld_um_i,
  output logic            ack_o,
  output logic            mask_o,
  output logic            um_o
);
  logic [3:0] cnt;
  logic [2:0] hold;

  // The answer stands only while the request does, so it is never taken late.
  assign ack_o = req_i && cnt == dly_i && hold == 3'h0;

  // Entry keeps the core busy until its raised masks reach the arbiter.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt  <= 4'h0;
      hold <= 3'h0;
    end else if (ack_o) begin
      cnt  <= 4'h0;
      hold <= 3'h4;
    end else begin
      if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end
      if (!req_i) begin
        cnt <= 4'h0;
      end else if (cnt != dly_i) begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // The core raises its masks on every entry, so a held flag cannot re-enter.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_o <= 1'b1;
      um_o   <= 1'b0;
    end else if (ld_i) begin
      mask_o <= ld_mask_i;
      um_o   <= ld_um_i;
    end else begin
      mask_o <= mask_o | set_i_i;
      um_o   <= um_o | set_um_i;
    end
  end
endmodule

// *** intc_pkg.sv ***
// Constants, register map and helper functions of the interrupt controller.
// How it works
// - After reset every request, the nonmaskable one too, is held off.
// - Hold-off ends only once the first program instruction has completed.
// - Seven external sources and thirty internal module sources are taken.
// - Each source is presented to the CPU with its own vector number.
// - The nonmaskable request wins over all others and ignores mask bits.
// - Maskable sources sit at one of two levels; simultaneous ones arbitrate.
// - A watchdog interval overflow pulse raises its own request.
// - A refresh interval compare match pulse raises its own request.
// - Trap sets the mask bit, and the user/mask bit too when enable is 0.
// - Trap vector is chosen by a two-bit number from zero to three.
// - Word and longword accesses force address bit zero low.
// - Acceptance masking has three levels from the mask and user/mask bits.
// - The nonmaskable input detects one edge, chosen by a control bit.
// - Each request pin selects falling-edge or low-level sensing alone.
// - Request flags read back; writing zero clears, writing one does nothing.
// - System control resets on reset and hardware standby only.
// - Enable bit 0 makes user/mask a mask, 1 a user bit; resets to 1.
// - Edge select 0 means falling edge, 1 means rising edge; resets to 0.
// - Reset exception handling sets the condition-code mask bit.
package intc_pkg;

  // Register indices; byte address on the bus is four times the index.
  localparam logic [15:0] SYSCTL_IDX    = 16'hfff2;
  localparam logic [15:0] SENSE_IDX     = 16'hfff4;
  localparam logic [15:0] ENABLE_IDX    = 16'hfff5;
  localparam logic [15:0] FLAGS_IDX     = 16'hfff6;
  localparam logic [15:0] PRIO_A_IDX    = 16'hfff8;
  localparam logic [15:0] PRIO_B_IDX    = 16'hfff9;

  localparam logic [7:0]  SYSCTL_RST    = 8'h0b;
  localparam logic [7:0]  SENSE_RST     = 8'h00;
  localparam logic [7:0]  ENABLE_RST    = 8'h00;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;
  localparam logic [7:0]  PRIO_A_RST    = 8'h00;
  localparam logic [7:0]  PRIO_B_RST    = 8'h00;

  localparam int          USER_EN_BIT   = 3;
  localparam int          EDGE_SEL_BIT  = 2;

  localparam int          N_PIN         = 6;
  localparam int          N_INT         = 30;
  localparam int          N_MOD         = 28;
  localparam int          N_SRC         = 36;

  localparam logic [5:0]  VEC_RESET     = 6'h00;
  localparam logic [5:0]  VEC_NMI       = 6'h07;
  localparam logic [5:0]  VEC_TRAP_BASE = 6'h08;
  localparam logic [5:0]  VEC_IRQ_BASE  = 6'h0c;
  localparam logic [5:0]  VEC_INT_BASE  = 6'h14;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_SYSCTL,
    SEL_SENSE,
    SEL_ENABLE,
    SEL_FLAGS,
    SEL_PRIO_A,
    SEL_PRIO_B
  } reg_sel_e;

  // Vector number of maskable source i (pins first, then internal sources).
  function automatic logic [5:0] vec_of(input int i);
    if (i < N_PIN) begin
      vec_of = VEC_IRQ_BASE + 6'(i);
    end else begin
      vec_of = VEC_INT_BASE + 6'(i - N_PIN);
    end
  endfunction

  // Priority bit position in {first, second} for maskable source i.
  function automatic int prio_pos(input int i);
    int g;
    g = 0;
    if (i == 0) begin
      prio_pos = 15;
    end else if (i == 1) begin
      prio_pos = 14;
    end else if (i < 4) begin
      prio_pos = 13;
    end else if (i < N_PIN) begin
      prio_pos = 12;
    end else if (i < N_PIN + 2) begin
      prio_pos = 11;
    end else begin
      g = (i - N_PIN - 2) / 3;
      prio_pos = (g < 6) ? (10 - g) : (9 - g);
    end
  endfunction

endpackage

// *** interrupt_priority_controller.sv ***
// Interrupt arbiter with its AHB-Lite register slave and CPU handshake.
`timescale 1ns/1ps
module interrupt_priority_controller
  import intc_pkg::*;
(
  input  wire logic                 SYS_CLK_I,
  input  wire logic                 RST_N_I,
  input  wire logic                 HSEL_I,
  input  wire logic [31:0]          HADDR_I,
  input  wire logic [1:0]           HTRANS_I,
  input  wire logic                 HWRITE_I,
  input  wire logic [2:0]           HSIZE_I,
  input  wire logic [31:0]          HWDATA_I,
  input  wire logic                 HREADY_I,
  output logic      [31:0]          HRDATA_O,
  output logic                      HREADYOUT_O,
  output logic                      HRESP_O,
  input  wire logic                 NMI_I,
  input  wire logic [N_PIN-1:0]     IRQ_N_I,
  input  wire logic                 WDT_OVF_I,
  input  wire logic                 REF_CMP_I,
  input  wire logic [N_MOD-1:0]     MOD_REQ_I,
  input  wire logic                 HW_STANDBY_I,
  input  wire logic                 COND_MASK_I,
  input  wire logic                 COND_USER_MASK_I,
  input  wire logic                 FIRST_INSN_DONE_I,
  input  wire logic                 INT_ACK_I,
  input  wire logic                 TRAP_I,
  input  wire logic [1:0]           TRAP_NUM_I,
  input  wire logic [23:0]          STACK_ADDR_I,
  input  wire logic                 ACCESS_WIDE_I,
  output logic                      INT_REQ_O,
  output logic      [5:0]           INT_VECTOR_O,
  output logic                      EXC_TAKE_O,
  output logic      [5:0]           EXC_VECTOR_O,
  output logic                      SET_MASK_O,
  output logic                      SET_USER_MASK_O,
  output logic      [23:0]          BUS_ADDR_O
);

  logic             nmi_s1;
  logic             nmi_s2;
  logic             nmi_s3;
  logic [N_PIN-1:0] irq_s1;
  logic [N_PIN-1:0] irq_s2;
  logic [N_PIN-1:0] irq_s3;
  logic [7:0]       sysctl;
  logic [N_PIN-1:0] sense;
  logic [N_PIN-1:0] enable;
  logic [N_PIN-1:0] flags;
  logic [7:0]       prio_a;
  logic [7:0]       prio_b;
  logic             dp_wr;
  reg_sel_e         dp_sel;
  logic             rd_wait;
  reg_sel_e         rd_sel;
  logic             blocked;
  logic             nmi_pend;
  logic             wdt_pend;
  logic             ref_pend;
  logic             ap_valid;
  logic             nmi_evt;
  logic [N_PIN-1:0] irq_set;
  logic [N_PIN-1:0] wdata6;
  logic             user_en;
  logic             allow_hi;
  logic             allow_lo;
  logic [N_SRC-1:0] src_req;
  logic [15:0]      prio16;
  logic             next_req;
  logic [5:0]       next_vec;

  // Address phase decode; only aligned words inside the map are selected.
  function automatic reg_sel_e decode_sel(input logic [31:0] a);
    if (a[31:18] != 14'h0000 || a[1:0] != 2'b00) begin
      decode_sel = SEL_NONE;
    end else if (a[17:2] == SYSCTL_IDX) begin
      decode_sel = SEL_SYSCTL;
    end else if (a[17:2] == SENSE_IDX) begin
      decode_sel = SEL_SENSE;
    end else if (a[17:2] == ENABLE_IDX) begin
      decode_sel = SEL_ENABLE;
    end else if (a[17:2] == FLAGS_IDX) begin
      decode_sel = SEL_FLAGS;
    end else if (a[17:2] == PRIO_A_IDX) begin
      decode_sel = SEL_PRIO_A;
    end else if (a[17:2] == PRIO_B_IDX) begin
      decode_sel = SEL_PRIO_B;
    end else begin
      decode_sel = SEL_NONE;
    end
  endfunction

  assign ap_valid    = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign HREADYOUT_O = ~rd_wait;
  assign HRESP_O     = 1'b0;
  assign wdata6      = HWDATA_I[N_PIN-1:0];
  assign user_en     = sysctl[USER_EN_BIT];

  // Bus capture; reads take one wait state so a write just before is seen.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dp_wr   <= 1'b0;
      dp_sel  <= SEL_NONE;
      rd_wait <= 1'b0;
      rd_sel  <= SEL_NONE;
    end else begin
      dp_wr   <= ap_valid & HWRITE_I;
      rd_wait <= ap_valid & ~HWRITE_I;
      if (ap_valid) begin
        dp_sel <= decode_sel(HADDR_I);
        rd_sel <= decode_sel(HADDR_I);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (rd_wait) begin
      case (rd_sel)
        SEL_SYSCTL: HRDATA_O <= {24'h000000, sysctl};
        SEL_SENSE:  HRDATA_O <= {26'h0, sense};
        SEL_ENABLE: HRDATA_O <= {26'h0, enable};
        SEL_FLAGS:  HRDATA_O <= {26'h0, flags};
        SEL_PRIO_A: HRDATA_O <= {24'h000000, prio_a};
        SEL_PRIO_B: HRDATA_O <= {24'h000000, prio_b};
        default:    HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers; standby is a synchronous return to reset values.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sysctl <= SYSCTL_RST;
      sense  <= SENSE_RST[N_PIN-1:0];
      enable <= ENABLE_RST[N_PIN-1:0];
      prio_a <= PRIO_A_RST;
      prio_b <= PRIO_B_RST;
    end else if (HW_STANDBY_I) begin
      sysctl <= SYSCTL_RST;
      sense  <= SENSE_RST[N_PIN-1:0];
      enable <= ENABLE_RST[N_PIN-1:0];
      prio_a <= PRIO_A_RST;
      prio_b <= PRIO_B_RST;
    end else if (dp_wr) begin
      case (dp_sel)
        SEL_SYSCTL: sysctl <= HWDATA_I[7:0];
        SEL_SENSE:  sense  <= wdata6;
        SEL_ENABLE: enable <= wdata6;
        SEL_PRIO_A: prio_a <= HWDATA_I[7:0];
        SEL_PRIO_B: prio_b <= HWDATA_I[7:0];
        default:    sysctl <= sysctl;
      endcase
    end
  end

  // Pins come from outside the clock domain: two stages, then a history.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      nmi_s3 <= 1'b1;
      irq_s1 <= '1;
      irq_s2 <= '1;
      irq_s3 <= '1;
    end else begin
      nmi_s1 <= NMI_I;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      irq_s1 <= IRQ_N_I;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
    end
  end

  assign nmi_evt = sysctl[EDGE_SEL_BIT] ? (nmi_s2 & ~nmi_s3)
                                        : (~nmi_s2 & nmi_s3);
  // Sense bit 1 catches a falling edge, 0 follows a low level.
  assign irq_set = (sense & irq_s3 & ~irq_s2) | (~sense & ~irq_s2);

  // Flags: a write of zero clears, and a new event in that cycle wins.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flags <= FLAGS_RST[N_PIN-1:0];
    end else if (HW_STANDBY_I) begin
      flags <= FLAGS_RST[N_PIN-1:0];
    end else if (dp_wr && dp_sel == SEL_FLAGS) begin
      flags <= (flags & wdata6) | irq_set;
    end else begin
      flags <= flags | irq_set;
    end
  end

  // Nothing is taken until the CPU reports its first instruction done.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      blocked <= 1'b1;
    end else if (FIRST_INSN_DONE_I) begin
      blocked <= 1'b0;
    end
  end

  // Event sources are latched until the CPU acknowledges their vector.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      nmi_pend <= 1'b0;
      wdt_pend <= 1'b0;
      ref_pend <= 1'b0;
    end else begin
      // Nonmaskable edges seen while blocked are dropped, as the stack is not ready.
      if (nmi_evt && !blocked) begin
        nmi_pend <= 1'b1;
      end else if (INT_ACK_I && INT_VECTOR_O == VEC_NMI) begin
        nmi_pend <= 1'b0;
      end
      if (WDT_OVF_I) begin
        wdt_pend <= 1'b1;
      end else if (INT_ACK_I && INT_VECTOR_O == VEC_INT_BASE) begin
        wdt_pend <= 1'b0;
      end
      if (REF_CMP_I) begin
        ref_pend <= 1'b1;
      end else if (INT_ACK_I && INT_VECTOR_O == VEC_INT_BASE + 6'h01) begin
        ref_pend <= 1'b0;
      end
    end
  end

  assign src_req = {MOD_REQ_I, ref_pend, wdt_pend, flags & enable};
  assign prio16  = {prio_a, prio_b};
  // With the enable bit set the user/mask bit is a plain user bit.
  assign allow_hi = ~COND_MASK_I | (~user_en & ~COND_USER_MASK_I);
  assign allow_lo = ~COND_MASK_I;

  // Scan downward so the lowest index, hence lowest vector, is kept.
  always_comb begin
    int hi_idx;
    int lo_idx;
    logic hi_hit;
    logic lo_hit;
    hi_idx   = 0;
    lo_idx   = 0;
    hi_hit   = 1'b0;
    lo_hit   = 1'b0;
    next_req = 1'b0;
    next_vec = INT_VECTOR_O;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (src_req[i] && prio16[prio_pos(i)]) begin
        hi_hit = 1'b1;
        hi_idx = i;
      end
      if (src_req[i] && !prio16[prio_pos(i)]) begin
        lo_hit = 1'b1;
        lo_idx = i;
      end
    end
    if (blocked || INT_ACK_I) begin
      next_req = 1'b0;
    end else if (nmi_pend) begin
      next_req = 1'b1;
      next_vec = VEC_NMI;
    end else if (hi_hit && allow_hi) begin
      next_req = 1'b1;
      next_vec = vec_of(hi_idx);
    end else if (lo_hit && allow_lo) begin
      next_req = 1'b1;
      next_vec = vec_of(lo_idx);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      INT_REQ_O    <= 1'b0;
      INT_VECTOR_O <= VEC_RESET;
    end else begin
      INT_REQ_O    <= next_req;
      INT_VECTOR_O <= next_vec;
    end
  end

  // Exception entry; the reset values form the reset exception pulse.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      EXC_TAKE_O      <= 1'b1;
      EXC_VECTOR_O    <= VEC_RESET;
      SET_MASK_O      <= 1'b1;
      SET_USER_MASK_O <= 1'b0;
    end else if (INT_ACK_I) begin
      EXC_TAKE_O      <= 1'b1;
      EXC_VECTOR_O    <= INT_VECTOR_O;
      SET_MASK_O      <= 1'b1;
      SET_USER_MASK_O <= ~user_en;
    end else if (TRAP_I) begin
      EXC_TAKE_O      <= 1'b1;
      EXC_VECTOR_O    <= VEC_TRAP_BASE + {4'h0, TRAP_NUM_I};
      SET_MASK_O      <= 1'b1;
      SET_USER_MASK_O <= ~user_en;
    end else begin
      EXC_TAKE_O      <= 1'b0;
      SET_MASK_O      <= 1'b0;
      SET_USER_MASK_O <= 1'b0;
    end
  end

  // Stack and other wide accesses are forced even.
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BUS_ADDR_O <= 24'h000000;
    end else if (ACCESS_WIDE_I) begin
      BUS_ADDR_O <= {STACK_ADDR_I[23:1], 1'b0};
    end else begin
      BUS_ADDR_O <= STACK_ADDR_I;
    end
  end

  a_reset_blocks: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $past(blocked) |-> !INT_REQ_O)
    else $error("request presented while blocked after reset");

  a_first_insn: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $fell(blocked) |-> $past(FIRST_INSN_DONE_I))
    else $error("hold-off ended without first instruction");

  a_nmi_wins: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (nmi_pend && !blocked && !INT_ACK_I) |=>
      (INT_REQ_O && INT_VECTOR_O == VEC_NMI))
    else $error("pending nonmaskable request not presented");

  a_mask_all: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (COND_MASK_I && user_en) |=> (!INT_REQ_O || INT_VECTOR_O == VEC_NMI))
    else $error("maskable request passed a full mask");

  a_flag_set_wins: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (|irq_set && !HW_STANDBY_I) |=> ((flags & $past(irq_set))
      == $past(irq_set)))
    else $error("flag event lost");

  a_flag_clear: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (dp_wr && dp_sel == SEL_FLAGS && irq_set == '0 && !HW_STANDBY_I)
      |=> flags == ($past(flags) & $past(wdata6)))
    else $error("flag write did not clear by zeros only");

  a_trap_bits: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (TRAP_I && !INT_ACK_I) |=> (SET_MASK_O && EXC_TAKE_O &&
      SET_USER_MASK_O == !$past(user_en)))
    else $error("trap set wrong mask bits");

  a_trap_vector: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (TRAP_I && !INT_ACK_I) |=>
      EXC_VECTOR_O == VEC_TRAP_BASE + {4'h0, $past(TRAP_NUM_I)})
    else $error("trap vector wrong");

  a_wdt_event: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    WDT_OVF_I |=> wdt_pend)
    else $error("watchdog overflow not latched");

  a_ref_event: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    REF_CMP_I |=> ref_pend)
    else $error("refresh compare match not latched");

  a_wide_even: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    ACCESS_WIDE_I |=> !BUS_ADDR_O[0])
    else $error("wide access left odd address");

  a_standby_rst: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    HW_STANDBY_I |=> sysctl == SYSCTL_RST)
    else $error("system control not reset in standby");

  a_nmi_fall: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (!sysctl[EDGE_SEL_BIT] && !nmi_s2 && nmi_s3 && !blocked) |=> nmi_pend)
    else $error("falling nonmaskable edge missed");

endmodule

// *** test_interrupt_priority_controller.sv ***
// Self-checking bench for the interrupt priority controller.
`timescale 1ns/1ps
module test_interrupt_priority_controller;
  import intc_pkg::*;
  logic             clk = 1'b0, rst_n = 1'b0, nmi = 1'b1, hwrite = 1'b0;
  logic             fdone = 1'b0, wdt = 1'b0, refc = 1'b0, trap = 1'b0;
  logic             hwstby = 1'b0, wide = 1'b0;
  logic             ld = 1'b0, ld_m = 1'b0, ld_u = 1'b0;
  logic [1:0]       htrans = 2'b00, tnum = 2'b00;
  logic [31:0]      haddr = 32'h0, hwdata = 32'h0;
  logic [5:0]       irq_n = 6'h3f;
  logic [N_MOD-1:0] mreq = '0;
  logic [23:0]      saddr = 24'h0;
  logic [3:0]       dly = 4'h0;
  logic             hrdy, hresp, ack, m_i, m_um, req, exc, sti, stum;
  logic [31:0]      hrdata;
  logic [5:0]       ivec, evec;
  logic [23:0]      baddr;
  int               n_fail = 0, check_count = 0, n_exc = 0, cyc = 0;
  logic [15:0]      idx [6] = '{SYSCTL_IDX, SENSE_IDX, ENABLE_IDX,
                                FLAGS_IDX, PRIO_A_IDX, PRIO_B_IDX};
  logic [7:0]       rv [6] = '{8'h0b, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 clk = ~clk;

  interrupt_priority_controller u_dut (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010),
    .HWDATA_I(hwdata), .HREADY_I(hrdy), .HRDATA_O(hrdata),
    .HREADYOUT_O(hrdy), .HRESP_O(hresp), .NMI_I(nmi), .IRQ_N_I(irq_n),
    .WDT_OVF_I(wdt), .REF_CMP_I(refc), .MOD_REQ_I(mreq),
    .HW_STANDBY_I(hwstby), .COND_MASK_I(m_i), .COND_USER_MASK_I(m_um),
    .FIRST_INSN_DONE_I(fdone), .INT_ACK_I(ack), .TRAP_I(trap),
    .TRAP_NUM_I(tnum), .STACK_ADDR_I(saddr), .ACCESS_WIDE_I(wide),
    .INT_REQ_O(req), .INT_VECTOR_O(ivec), .EXC_TAKE_O(exc),
    .EXC_VECTOR_O(evec), .SET_MASK_O(sti), .SET_USER_MASK_O(stum),
    .BUS_ADDR_O(baddr));

  cpu_model u_cpu (
    .clk_i(clk), .rst_n_i(rst_n), .req_i(req), .dly_i(dly),
    .set_i_i(sti), .set_um_i(stum), .ld_i(ld), .ld_mask_i(ld_m),
    .ld_um_i(ld_u), .ack_o(ack), .mask_o(m_i), .um_o(m_um));

  // Entries are counted off the sampling edge so the count never races.
  always @(negedge clk) begin
    if (rst_n && exc === 1'b1) n_exc++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    logic ok;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do begin
      @(negedge clk);
      ok = hrdy;
      @(posedge clk);
    end while (ok !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge clk);
      ok = hrdy;
      r  = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, {14'h0, i, 2'b00}, {24'h0, d}, r);
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] e, string nm);
    logic [31:0] r;
    bus(1'b0, {14'h0, i, 2'b00}, 32'h0, r);
    chk(nm, r, {24'h0, e});
  endtask

  task automatic pulse(input logic [4:0] m);
    {hwstby, trap, refc, wdt, fdone} <= m;
    @(posedge clk);
    {hwstby, trap, refc, wdt, fdone} <= 5'h00;
    @(posedge clk);
  endtask

  task automatic cond(input logic i, input logic um);
    ld   <= 1'b1;
    ld_m <= i;
    ld_u <= um;
    @(posedge clk);
    ld <= 1'b0;
    @(posedge clk);
  endtask

  task automatic take(input logic [5:0] v, input logic um, string nm);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (exc !== 1'b1 && k < 30);
    chk("entry", 32'(exc), 32'h1);
    chk(nm, 32'(evec), 32'(v));
    chk("mask set", 32'(sti), 32'h1);
    chk("user mask set", 32'(stum), 32'(um));
    @(posedge clk);
  endtask

  task automatic quiet(input int n, string nm);
    int e;
    e = n_exc;
    repeat (n) @(posedge clk);
    chk(nm, 32'(n_exc), 32'(e));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset entry", 32'(exc), 32'h1);
    chk("reset mask", 32'(sti), 32'h1);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      rd(idx[k], rv[k], "reset value");
    end
    rd(16'hfff3, 8'h00, "unmapped");
    wr(SYSCTL_IDX, 8'h03);
    rd(SYSCTL_IDX, 8'h03, "system control");
    wr(PRIO_A_IDX, 8'hff);
    wr(FLAGS_IDX, 8'hff);
    rd(FLAGS_IDX, 8'h00, "flags write one");
    pulse(5'h10);
    rd(SYSCTL_IDX, 8'h0b, "standby control");
    rd(PRIO_A_IDX, 8'h00, "standby priority");
    $display("test registers done");
    nmi <= 1'b0;
    quiet(10, "blocked nmi");
    nmi <= 1'b1;
    pulse(5'h01);
    quiet(8, "discarded edge");
    $display("test blocking done");
    cond(1'b1, 1'b1);
    nmi <= 1'b0;
    take(6'd7, 1'b0, "nmi falling");
    wr(SYSCTL_IDX, 8'h0f);
    nmi <= 1'b1;
    take(6'd7, 1'b0, "nmi rising");
    nmi <= 1'b0;
    quiet(10, "nmi other edge");
    $display("test nonmaskable done");
    for (int u = 0; u < 2; u++) begin
      wr(SYSCTL_IDX, (u == 0) ? 8'h0b : 8'h03);
      for (int n = 0; n < 4; n++) begin
        tnum <= 2'(n);
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        take(6'(8 + n), 1'(u), "trap vector");
      end
    end
    $display("test trap done");
    wr(SENSE_IDX, 8'h01);
    wr(ENABLE_IDX, 8'h03);
    cond(1'b0, 1'b0);
    irq_n <= 6'h3e;
    take(6'd12, 1'b1, "edge pin");
    irq_n <= 6'h3c;
    quiet(10, "masked pin");
    rd(FLAGS_IDX, 8'h03, "flags set");
    wr(FLAGS_IDX, 8'hfd);
    rd(FLAGS_IDX, 8'h03, "flag kept");
    wr(FLAGS_IDX, 8'hfe);
    rd(FLAGS_IDX, 8'h02, "flag cleared");
    cond(1'b0, 1'b0);
    take(6'd13, 1'b1, "level pin");
    irq_n <= 6'h3f;
    // The released pin must clear its synchroniser before the flag clear.
    repeat (3) @(posedge clk);
    wr(FLAGS_IDX, 8'h00);
    rd(FLAGS_IDX, 8'h00, "flags clear");
    $display("test pins done");
    dly <= 4'h3;
    wr(PRIO_A_IDX, 8'h08);
    wr(PRIO_B_IDX, 8'h01);
    cond(1'b1, 1'b0);
    irq_n <= 6'h3e;
    pulse(5'h06);
    take(6'd20, 1'b1, "watchdog first");
    cond(1'b1, 1'b0);
    take(6'd21, 1'b1, "refresh next");
    mreq[27] <= 1'b1;
    cond(1'b0, 1'b0);
    take(6'd49, 1'b1, "level one first");
    mreq[27] <= 1'b0;
    cond(1'b0, 1'b0);
    take(6'd12, 1'b1, "level zero last");
    $display("test priority done");
    saddr <= 24'h001235;
    wide  <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("wide address", 32'(baddr), 32'h1234);
    @(posedge clk);
    wide <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("byte address", 32'(baddr), 32'h1235);
    $display("test alignment done");
    test_done();
  end
endmodule
